// [core/fsac_capture.v]
// fsac_capture.v: one fault address holding register with valid flag.
// assumes fault strobes come from logic on the same clock.
`timescale 1ns/1ps
`include "fsac_regs.vh"
module fsac_capture #(
   parameter W = 32
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // fault capture
   input wire fault,
   input wire [W-1:0] fault_addr,
   input wire clear_valid,
   // software write
   input wire sw_we,
   input wire [W-1:0] sw_data,
   // state
   output reg [W-1:0] addr,
   output reg valid
);
   always @(posedge clk) begin
      if (rst) begin
         addr <= `FSAC_ADDR_RESET;
         valid <= 1'b0;
      end else begin
         // a fault in the same cycle as a software write wins
         if (fault)
            addr <= fault_addr;
         else if (sw_we)
            addr <= sw_data;
         if (fault)
            valid <= 1'b1;
         else if (clear_valid)
            valid <= 1'b0;
      end
   end
endmodule // fsac_capture

// [core/fsac_regs.vh]
// fsac_regs.vh: offsets, field positions and reset values of the fault
// status and fault address registers.
// assumes byte offsets on a 12-bit word-aligned register port.
`ifndef FSAC_REGS_VH
`define FSAC_REGS_VH
`define FSAC_AW 12
`define FSAC_OFF_HFSR 12'hd2c
`define FSAC_OFF_MMAR 12'hd34
`define FSAC_OFF_BFAR 12'hd38
`define FSAC_OFF_IRQ_STAT 12'hd40
`define FSAC_OFF_IRQ_MASK 12'hd44
`define FSAC_OFF_VALID 12'hd48
`define FSAC_BIT_DEBUG 31
`define FSAC_BIT_FORCED 30
`define FSAC_BIT_VECT 1
`define FSAC_HFSR_RESET 32'h00000000
`define FSAC_ADDR_RESET 32'h00000000
`define FSAC_IRQ_W 4
`define FSAC_IRQ_FORCED 0
`define FSAC_IRQ_VECT 1
`define FSAC_IRQ_MM 2
`define FSAC_IRQ_BUS 3
`define FSAC_IRQ_RESET 4'h0
`define FSAC_VALID_MM 0
`define FSAC_VALID_BUS 1
`endif

// [core/fsac_sync.v]
// fsac_sync.v: three-stage synchroniser with agreement filter.
// assumes d comes from outside the MCLK domain.
`timescale 1ns/1ps
module fsac_sync (
   // clock and reset
   input wire clk,
   input wire rst,
   // level in and filtered level out
   input wire d,
   output reg q
);
   reg s1;
   reg s2;
   reg s3;
   // s1 feeds only s2 so metastability cannot reach the filter
   always @(posedge clk) begin
      if (rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         q <= 1'b0;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            q <= s3;
      end
   end
endmodule // fsac_sync

// [core/fsac_top.v]
// fsac_top.v: hard fault status flags plus memory-management and bus
// fault address capture, with a privileged-only register port.
// assumes fault event inputs are one-cycle pulses on MCLK; the debug
// event input comes from a foreign domain and is synchronised.
// Summary of operation
// - forced flag sets on escalation of a blocked configurable fault
// - vector flag sets on a bus fault during a vector table read
// - bits 29 to 2 and bit 0 read zero, ignore writes
// - memory-management fault captures the faulting address
// - unaligned memory fault stores the actual faulting address
// - split access may report any address within the access span
// - memory fault address meaningful only while its valid flag set
// - bus fault captures the faulting address
// - unaligned bus fault stores the requested address
// - bus fault address valid only while its valid flag set
// - registers reachable only in privileged mode; others refused
// - status flags clear on write one, zero leaves them
// - instruction access violations do not capture an address
// - debug bit is write-one-to-clear and resets to zero
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "fsac_regs.vh"
module fsac_top #(
   parameter AW = `FSAC_AW,
   parameter DW = 32
) (
   // clock and reset
   input wire MCLK,
   input wire RST,
   // register port
   input wire [AW-1:0] ADDR,
   input wire [DW-1:0] WDATA,
   input wire WR,
   input wire RD,
   input wire PRIV,
   output reg [DW-1:0] RDATA,
   output reg ERR,
   // fault detection events
   input wire ESCALATE_FAULT,
   input wire VECTOR_BUS_FAULT,
   input wire DEBUG_EVENT,
   input wire MM_DATA_FAULT,
   input wire MM_INSTR_FAULT,
   input wire [DW-1:0] MM_ACTUAL_ADDR,
   input wire BUS_FAULT,
   input wire [DW-1:0] BUS_REQ_ADDR,
   // status out
   output reg MEM_MANAGE_ADDRESS_VALID,
   output reg BUS_ADDRESS_VALID,
   output reg IRQ
);
   reg forced_flag;
   reg vect_flag;
   reg debug_reserved_flag;
   reg debug_seen;
   wire [`FSAC_IRQ_W-1:0] irq_stat;
   reg [`FSAC_IRQ_W-1:0] irq_mask;
   reg [DW-1:0] next_rdata;
   reg next_err;
   wire debug_level;
   wire debug_rise;
   wire [DW-1:0] mem_manage_fault_address;
   wire [DW-1:0] bus_fault_address;
   wire mm_valid;
   wire bus_valid;
   wire [`FSAC_IRQ_W-1:0] irq_event;
   wire wr_ok;
   wire rd_ok;
   wire wr_hfsr;
   wire wr_valid;

   // unprivileged accesses never reach the registers
   assign wr_ok = WR & PRIV;
   assign rd_ok = RD & PRIV;
   assign wr_hfsr = wr_ok && ADDR == `FSAC_OFF_HFSR;
   assign wr_valid = wr_ok && ADDR == `FSAC_OFF_VALID;

   fsac_sync u_dbg_sync (
      .clk(MCLK),
      .rst(RST),
      .d(DEBUG_EVENT),
      .q(debug_level)
   );

   assign debug_rise = debug_level & ~debug_seen;

   // only data access violations load the address; the core supplies
   // the actual faulting beat address, any beat of a split access
   fsac_capture #(.W(DW)) u_mm (
      .clk(MCLK),
      .rst(RST),
      .fault(MM_DATA_FAULT),
      .fault_addr(MM_ACTUAL_ADDR),
      .clear_valid(wr_valid & WDATA[`FSAC_VALID_MM]),
      .sw_we(wr_ok && ADDR == `FSAC_OFF_MMAR),
      .sw_data(WDATA),
      .addr(mem_manage_fault_address),
      .valid(mm_valid)
   );

   // bus faults record the address the instruction requested
   fsac_capture #(.W(DW)) u_bus (
      .clk(MCLK),
      .rst(RST),
      .fault(BUS_FAULT),
      .fault_addr(BUS_REQ_ADDR),
      .clear_valid(wr_valid & WDATA[`FSAC_VALID_BUS]),
      .sw_we(wr_ok && ADDR == `FSAC_OFF_BFAR),
      .sw_data(WDATA),
      .addr(bus_fault_address),
      .valid(bus_valid)
   );

   // status flags: a new event beats a same-cycle clear
   always @(posedge MCLK) begin
      if (RST) begin
         forced_flag <= 1'b0;
         vect_flag <= 1'b0;
         debug_reserved_flag <= 1'b0;
         debug_seen <= 1'b0;
      end else begin
         debug_seen <= debug_level;
         if (ESCALATE_FAULT)
            forced_flag <= 1'b1;
         else if (wr_hfsr && WDATA[`FSAC_BIT_FORCED])
            forced_flag <= 1'b0;
         if (VECTOR_BUS_FAULT)
            vect_flag <= 1'b1;
         else if (wr_hfsr && WDATA[`FSAC_BIT_VECT])
            vect_flag <= 1'b0;
         if (debug_rise)
            debug_reserved_flag <= 1'b1;
         else if (wr_hfsr && WDATA[`FSAC_BIT_DEBUG])
            debug_reserved_flag <= 1'b0;
      end
   end

   assign irq_event[`FSAC_IRQ_FORCED] = ESCALATE_FAULT;
   assign irq_event[`FSAC_IRQ_VECT] = VECTOR_BUS_FAULT;
   assign irq_event[`FSAC_IRQ_MM] = MM_DATA_FAULT;
   assign irq_event[`FSAC_IRQ_BUS] = BUS_FAULT;

   genvar i;
   generate
      for (i = 0; i < `FSAC_IRQ_W; i = i + 1) begin : g_irq
         // each bit owns its flop so the vector has a single driver
         reg bit_set;
         always @(posedge MCLK) begin
            if (RST)
               bit_set <= 1'b0;
            else if (irq_event[i])
               bit_set <= 1'b1;
            else if (wr_ok && ADDR == `FSAC_OFF_IRQ_STAT && WDATA[i])
               bit_set <= 1'b0;
         end
         assign irq_stat[i] = bit_set;
      end
   endgenerate

   always @(posedge MCLK) begin
      if (RST)
         irq_mask <= `FSAC_IRQ_RESET;
      else if (wr_ok && ADDR == `FSAC_OFF_IRQ_MASK)
         irq_mask <= WDATA[`FSAC_IRQ_W-1:0];
   end

   // read mux; reserved hfsr bits are simply never driven
   always @* begin
      next_rdata = {DW{1'b0}};
      next_err = 1'b0;
      if (RD && !PRIV) begin
         next_err = 1'b1;
      end else if (rd_ok) begin
         case (ADDR)
            `FSAC_OFF_HFSR: begin
               next_rdata[`FSAC_BIT_DEBUG] = debug_reserved_flag;
               next_rdata[`FSAC_BIT_FORCED] = forced_flag;
               next_rdata[`FSAC_BIT_VECT] = vect_flag;
            end
            `FSAC_OFF_MMAR: next_rdata = mem_manage_fault_address;
            `FSAC_OFF_BFAR: next_rdata = bus_fault_address;
            `FSAC_OFF_IRQ_STAT: next_rdata[`FSAC_IRQ_W-1:0] = irq_stat;
            `FSAC_OFF_IRQ_MASK: next_rdata[`FSAC_IRQ_W-1:0] = irq_mask;
            `FSAC_OFF_VALID: begin
               next_rdata[`FSAC_VALID_MM] = mm_valid;
               next_rdata[`FSAC_VALID_BUS] = bus_valid;
            end
            default: next_rdata = {DW{1'b0}};
         endcase
      end
      if (WR && !PRIV)
         next_err = 1'b1;
   end

   always @(posedge MCLK) begin
      if (RST) begin
         RDATA <= {DW{1'b0}};
         ERR <= 1'b0;
         IRQ <= 1'b0;
         MEM_MANAGE_ADDRESS_VALID <= 1'b0;
         BUS_ADDRESS_VALID <= 1'b0;
      end else begin
         RDATA <= next_rdata;
         ERR <= next_err;
         IRQ <= |(irq_stat & irq_mask);
         MEM_MANAGE_ADDRESS_VALID <= mm_valid;
         BUS_ADDRESS_VALID <= bus_valid;
      end
   end
endmodule // fsac_top

// [tb/fsac_fault_src.sv]
// fsac_fault_src.sv: core-side fault detection model.
// assumes go is a one-cycle pulse from the bench on MCLK.
`timescale 1ns/1ps
module fsac_fault_src (
   // command from the bench
   input wire go,
   input wire [2:0] kind,
   input wire [31:0] req,
   input wire [1:0] off,
   // fault events to the block
   output wire esc,
   output wire vect,
   output wire mm_data,
   output wire mm_instr,
   output wire bus,
   output wire [31:0] mm_addr,
   output wire [31:0] bus_addr
);
   assign esc = go && kind == 3'h0;
   assign vect = go && kind == 3'h1;
   assign mm_data = go && kind == 3'h2;
   assign mm_instr = go && kind == 3'h3;
   assign bus = go && kind == 3'h4;
   // split access faults on a byte inside the span; idle lines invert
   assign mm_addr = go ? req + off : ~req;
   assign bus_addr = go ? req : ~req;
endmodule // fsac_fault_src

// [tb/fsac_top_monitor.sv]
// fsac_top_monitor.sv: port assertions for the fault status block.
// assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
`include "fsac_regs.vh"
module fsac_mon #(
   parameter AW = 12,
   parameter DW = 32
) (
   // clock, reset and register port
   input wire MCLK,
   input wire RST,
   input wire [AW-1:0] ADDR,
   input wire WR,
   input wire RD,
   input wire PRIV,
   input wire [DW-1:0] RDATA,
   input wire ERR,
   // fault events and valid levels
   input wire ESCALATE_FAULT,
   input wire MM_DATA_FAULT,
   input wire [DW-1:0] MM_ACTUAL_ADDR,
   input wire BUS_FAULT,
   input wire [DW-1:0] BUS_REQ_ADDR,
   input wire BUS_ADDRESS_VALID
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   wire prd = RD & PRIV;
   refused_err_a: assert property ((WR | RD) && !PRIV |=> ERR)
      else $error("no refusal");
   granted_ok_a: assert property ((WR | RD) && PRIV |=> !ERR)
      else $error("false refusal");
   refused_data_a: assert property (RD && !PRIV |=> RDATA == 0)
      else $error("refused read leaks data");
   bus_valid_a: assert property (BUS_FAULT ##1 !WR
      |=> BUS_ADDRESS_VALID)
      else $error("bus valid late");
   bfar_read_a: assert property (BUS_FAULT ##1 prd && ADDR == 12'hd38
      |=> RDATA == $past(BUS_REQ_ADDR, 2))
      else $error("bus address not captured");
   mmar_read_a: assert property (MM_DATA_FAULT ##1 prd
      && ADDR == 12'hd34 |=> RDATA == $past(MM_ACTUAL_ADDR, 2))
      else $error("memory address not captured");
   hfsr_zero_a: assert property (prd && ADDR == 12'hd2c
      |=> RDATA[29:2] == 0 && !RDATA[0])
      else $error("reserved status bits set");
   forced_set_a: assert property (ESCALATE_FAULT ##1 prd
      && ADDR == 12'hd2c |=> RDATA[`FSAC_BIT_FORCED])
      else $error("forced flag not set");
   cover property (BUS_FAULT);
   cover property (MM_DATA_FAULT);
   cover property (ERR);
endmodule // fsac_mon
bind fsac_top fsac_mon #(.AW(AW), .DW(DW)) i_mon (.*);

// [tb/tb_fsac_top.sv]
// tb_fsac_top.sv: self-checking bench with an integer register model.
// assumes read data and refusal stand one cycle after the strobe.
`timescale 1ns/1ps
module tb_fsac_top;
   reg mclk = 0, rst = 1, wr = 0, rd = 0, priv = 1, dbg = 0, go = 0;
   reg [11:0] addr = 0;
   reg [31:0] wdata = 0, req = 0;
   reg [2:0] kind = 0;
   reg [1:0] off = 0;
   wire [31:0] rdata, mma, bua;
   wire err, esc, vect, mmd, mmi, bus, mmv, bv, irq;
   integer n_errors = 0, checks_done = 0, cyc = 0, i, r;
   integer hfsr = 0, mmar = 0, bfar = 0, stat = 0, mask = 0, vld = 0;
   reg [11:0] map [0:6] = '{12'hd2c, 12'hd34, 12'hd38, 12'hd40,
      12'hd44, 12'hd48, 12'hd3c};
   reg [11:0] nxt [0:4] = '{12'hd2c, 12'hd2c, 12'hd34, 12'hd34, 12'hd38};
   fsac_top i_dut (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .PRIV(priv), .RDATA(rdata), .ERR(err),
      .ESCALATE_FAULT(esc), .VECTOR_BUS_FAULT(vect), .DEBUG_EVENT(dbg),
      .MM_DATA_FAULT(mmd), .MM_INSTR_FAULT(mmi), .MM_ACTUAL_ADDR(mma),
      .BUS_FAULT(bus), .BUS_REQ_ADDR(bua), .IRQ(irq),
      .MEM_MANAGE_ADDRESS_VALID(mmv), .BUS_ADDRESS_VALID(bv));
   fsac_fault_src i_src (.go(go), .kind(kind), .req(req), .off(off),
      .esc(esc), .vect(vect), .mm_data(mmd), .mm_instr(mmi), .bus(bus),
      .mm_addr(mma), .bus_addr(bua));
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_errors = n_errors + 1;
         final_report;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("FAIL %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   function [31:0] mread(input [11:0] a);
      case (a)
         12'hd2c: mread = hfsr;
         12'hd34: mread = mmar;
         12'hd38: mread = bfar;
         12'hd40: mread = stat;
         12'hd44: mread = mask;
         12'hd48: mread = vld;
         default: mread = 0;
      endcase
   endfunction
   task wrt(input [11:0] a, input [31:0] d, input p);
      begin
         addr <= a;
         wdata <= d;
         priv <= p;
         wr <= 1;
         @(posedge mclk);
         wr <= 0;
         if (p) begin
            if (a == 12'hd2c) hfsr = hfsr & ~(d & 32'h40000002);
            if (a == 12'hd34) mmar = d;
            if (a == 12'hd38) bfar = d;
            if (a == 12'hd40) stat = stat & ~d;
            if (a == 12'hd44) mask = d & 15;
            if (a == 12'hd48) vld = vld & ~d;
         end
         #1 chk(err, !p);
         @(posedge mclk);
      end
   endtask
   task rdc(input [11:0] a, input p);
      begin
         addr <= a;
         priv <= p;
         rd <= 1;
         @(posedge mclk);
         rd <= 0;
         #1 chk(rdata, p ? mread(a) : 0);
         chk(err, !p);
         @(posedge mclk);
      end
   endtask
   task ev(input [2:0] k);
      reg [31:0] q;
      reg [1:0] o;
      begin
         q = $urandom;
         o = $urandom;
         go <= 1;
         kind <= k;
         req <= q;
         off <= o;
         @(posedge mclk);
         go <= 0;
         if (k == 0) hfsr[30] = 1;
         if (k == 1) hfsr[1] = 1;
         if (k == 2) mmar = q + o;
         if (k == 4) bfar = q;
         if (k != 3) stat[k == 4 ? 3 : k] = 1;
         if (k == 2 || k == 4) vld[k / 4] = 1;
      end
   endtask
   task irqc;
      begin
         repeat (2) @(posedge mclk);
         #1 chk(irq, |(stat & mask));
         chk(mmv, vld[0]);
         chk(bv, vld[1]);
         @(posedge mclk);
      end
   endtask
   task final_report;
      begin
         $display("checks %0d errors %0d", checks_done, n_errors);
         if (n_errors == 0 && checks_done > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   initial begin
      r = $urandom(71);
      repeat (6) @(posedge mclk);
      rst <= 0;
      for (i = 0; i < 7; i = i + 1) rdc(map[i], 1);
      wrt(12'hd2c, 32'h7fffffff, 1);
      for (i = 0; i < 5; i = i + 1) begin
         ev(i);
         rdc(nxt[i], 1);
      end
      for (i = 0; i < 7; i = i + 1) rdc(map[i], 1);
      irqc;
      wrt(12'hd44, 32'h8, 1);
      irqc;
      wrt(12'hd44, 32'hf, 1);
      wrt(12'hd40, 32'h9, 1);
      irqc;
      wrt(12'hd2c, 0, 1);
      rdc(12'hd2c, 1);
      wrt(12'hd2c, 32'h40000000, 1);
      rdc(12'hd2c, 1);
      wrt(12'hd34, $urandom, 0);
      rdc(12'hd34, 0);
      rdc(12'hd34, 1);
      wrt(12'hd38, $urandom, 1);
      rdc(12'hd38, 1);
      ev(4);
      rdc(12'hd38, 1);
      wrt(12'hd48, 32'h3, 1);
      irqc;
      dbg <= 1;
      repeat (8) @(posedge mclk);
      hfsr[31] = 1;
      rdc(12'hd2c, 1);
      final_report;
   end
endmodule // tb_fsac_top
